// File: rtl/rcb_regs.svh
`ifndef RCB_REGS_SVH
`define RCB_REGS_SVH
// Function
// - enable bit clear puts reference output B in high impedance
// - enable bit set drives selected clock; enable resets to one
// - rate flag marks external clock B as T1 (0, reset) or E1 (1)
// - selector value n from 0 to 21 picks channel n recovered clock
// - selector values 22 to 31 pick the external clock B input
// - selector resets to channel 1
// - summary register low maps channels 8..1 onto bits 7..0
// - summary register mid maps channels 16..9 onto bits 7..0
// - summary bit reads one when any channel interrupt pending
// - summary bit reads zero when none pending; resets to zero

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RCB_REF_B_CLOCK_SELECT_OFS  12'h280
`define RCB_CHAN_IRQ_SUMMARY_LOW_OFS 12'h2C0
`define RCB_CHAN_IRQ_SUMMARY_MID_OFS 12'h300
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define RCB_ENABLE_BIT   6
`define RCB_RATE_BIT     5
`define RCB_SRC_MSB      4
`define RCB_ENABLE_RST   1'h1
`define RCB_RATE_RST     1'h0
`define RCB_SRC_RST      5'h01
`define RCB_SRC_LAST_CH  5'h15
`define RCB_NUM_CH       22
`endif

// File: rtl/rcb_pkg.sv
package rcb_pkg;
  // fields of the reference output B configuration register
  typedef struct packed {
    logic       enable;
    logic       rate_e1;
    logic [4:0] source;
  } rcb_cfg_t;

  // apb slave request as seen by the block
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rcb_apb_req_t;
endpackage

// File: rtl/rcb_or_reduce.sv
`timescale 1ns/10ps
// one channel's summary: OR of its pending flags
module rcb_or_reduce #(
  parameter int FLAGS = 8
) (
  input  wire logic [FLAGS-1:0] flags_i,
  output logic                  any_o
);
  assign any_o = |flags_i;
endmodule

// File: rtl/rcb_clk_mux.sv
`timescale 1ns/10ps
// source selection for reference output B
module rcb_clk_mux #(
  parameter int NUM_CH = 22
) (
  input  wire logic [NUM_CH-1:0] rec_clk_i,
  input  wire logic              ext_clk_i,
  input  wire logic [4:0]        source_i,
  output logic                   clk_o
);
  always_comb begin
    if (source_i <= 5'(NUM_CH - 1)) begin
      clk_o = rec_clk_i[source_i];
    end else begin
      clk_o = ext_clk_i;
    end
  end
endmodule

// File: rtl/rcb_top.sv
`timescale 1ns/10ps
`include "rcb_regs.svh"
// reference output B selection and channel interrupt summary
module rcb_top #(
  parameter int NUM_CH    = `RCB_NUM_CH,
  parameter int FLAGS_CH  = 8
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic [31:0]                prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic [NUM_CH-1:0]     rec_clk_i,
  input  wire logic                  ext_clk_b_in_i,
  input  wire logic [16*FLAGS_CH-1:0] chan_flags_i,
  output logic                       ref_out_b_o,
  output logic                       ref_out_b_oe_o,
  output logic                       ext_clk_b_rate_sel_o
);
  import rcb_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  rcb_apb_req_t req;
  rcb_cfg_t     cfg_reg;
  logic         acc_wr;
  logic         hit_cfg;
  logic         hit_low;
  logic         hit_mid;
  logic [15:0]  summary;
  logic         mux_clk;

  assign req     = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};
  assign hit_cfg = req.paddr == `RCB_REF_B_CLOCK_SELECT_OFS;
  assign hit_low = req.paddr == `RCB_CHAN_IRQ_SUMMARY_LOW_OFS;
  assign hit_mid = req.paddr == `RCB_CHAN_IRQ_SUMMARY_MID_OFS;
  // access phase waits one cycle for the answer; pready is registered
  // so the answer lands one cycle after penable rises
  assign acc_wr  = req.psel && req.penable && pready_o && req.pwrite;

  // answer one cycle into the access phase, then drop for one cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= req.psel && req.penable && !pready_o;
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cfg_reg.enable  <= `RCB_ENABLE_RST;
      cfg_reg.rate_e1 <= `RCB_RATE_RST;
      cfg_reg.source  <= `RCB_SRC_RST;
    end else if (acc_wr && hit_cfg) begin
      cfg_reg.enable  <= req.pwdata[`RCB_ENABLE_BIT];
      cfg_reg.rate_e1 <= req.pwdata[`RCB_RATE_BIT];
      cfg_reg.source  <= req.pwdata[`RCB_SRC_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // channel summaries 1..16
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_sum
      rcb_or_reduce #(
        .FLAGS (FLAGS_CH)
      ) u_or (
        .flags_i (chan_flags_i[g*FLAGS_CH +: FLAGS_CH]),
        .any_o   (summary[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data and error
  // ----------------------------------------------------------------
  // data is registered with pready; reserved bit 7 reads zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (req.psel && req.penable && !pready_o) begin
      pslverr_o <= !(hit_cfg || hit_low || hit_mid);
      if (req.pwrite) begin
        prdata_o <= 32'h0000_0000;
      end else if (hit_cfg) begin
        prdata_o <= {25'h0, cfg_reg};
      end else if (hit_low) begin
        prdata_o <= {24'h0, summary[7:0]};
      end else if (hit_mid) begin
        prdata_o <= {24'h0, summary[15:8]};
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // reference output B
  // ----------------------------------------------------------------
  rcb_clk_mux #(
    .NUM_CH (NUM_CH)
  ) u_mux (
    .rec_clk_i (rec_clk_i),
    .ext_clk_i (ext_clk_b_in_i),
    .source_i  (cfg_reg.source),
    .clk_o     (mux_clk)
  );

  // registered so every output leaves a flop; this samples the
  // chosen clock, so it only passes clocks well below sys_clk
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ref_out_b_o          <= 1'b0;
      ref_out_b_oe_o       <= 1'b1;
      ext_clk_b_rate_sel_o <= 1'b0;
    end else begin
      ref_out_b_o          <= mux_clk & cfg_reg.enable;
      ref_out_b_oe_o       <= cfg_reg.enable;
      ext_clk_b_rate_sel_o <= cfg_reg.rate_e1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_oe_follows;
    @(posedge sys_clk_i) disable iff (srst_i)
    1'b1 |=> ref_out_b_oe_o == $past(cfg_reg.enable);
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("oe does not follow enable");

  property p_off_low;
    @(posedge sys_clk_i) disable iff (srst_i)
    !cfg_reg.enable |=> !ref_out_b_o;
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("output driven while disabled");

  property p_rst_vals;
    @(posedge sys_clk_i)
    srst_i |=> cfg_reg.enable && !cfg_reg.rate_e1 && cfg_reg.source == 5'h01;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("configuration reset value wrong");

  property p_rate;
    @(posedge sys_clk_i) disable iff (srst_i)
    1'b1 |=> ext_clk_b_rate_sel_o == $past(cfg_reg.rate_e1);
  endproperty
  a_rate: assert property (p_rate)
    else $error("rate flag mismatch");

  property p_chan;
    @(posedge sys_clk_i) disable iff (srst_i)
    cfg_reg.source <= `RCB_SRC_LAST_CH && cfg_reg.enable
      |=> ref_out_b_o == $past(rec_clk_i[cfg_reg.source]);
  endproperty
  a_chan: assert property (p_chan)
    else $error("wrong channel clock");

  property p_ext;
    @(posedge sys_clk_i) disable iff (srst_i)
    cfg_reg.source > `RCB_SRC_LAST_CH && cfg_reg.enable
      |=> ref_out_b_o == $past(ext_clk_b_in_i);
  endproperty
  a_ext: assert property (p_ext)
    else $error("external clock not routed");

  sequence s_rd_low;
    psel_i && penable_i && !pwrite_i && !pready_o && hit_low;
  endsequence
  property p_low;
    @(posedge sys_clk_i) disable iff (srst_i)
    s_rd_low |=> prdata_o[7:0] == $past(summary[7:0]) && pready_o;
  endproperty
  a_low: assert property (p_low)
    else $error("low summary read wrong");

  sequence s_rd_mid;
    psel_i && penable_i && !pwrite_i && !pready_o && hit_mid;
  endsequence
  property p_mid;
    @(posedge sys_clk_i) disable iff (srst_i)
    s_rd_mid |=> prdata_o[7:0] == $past(summary[15:8]) && pready_o;
  endproperty
  a_mid: assert property (p_mid)
    else $error("mid summary read wrong");

  // checked where software sees them rather than on the summary net,
  // so a broken or-tree or a swapped bit shows up as well
  property p_sum_one;
    @(posedge sys_clk_i) disable iff (srst_i)
    psel_i && penable_i && !pwrite_i && !pready_o && hit_low
      && |chan_flags_i[FLAGS_CH-1:0] |=> prdata_o[0];
  endproperty
  a_sum_one: assert property (p_sum_one)
    else $error("pending channel not summarised");

  property p_sum_zero;
    @(posedge sys_clk_i) disable iff (srst_i)
    psel_i && penable_i && !pwrite_i && !pready_o && hit_low
      && chan_flags_i[2*FLAGS_CH-1:FLAGS_CH] == '0 |=> !prdata_o[1];
  endproperty
  a_sum_zero: assert property (p_sum_zero)
    else $error("idle channel summarised");

  // the top channel of the mid register lands in its top bit
  property p_sum_top;
    @(posedge sys_clk_i) disable iff (srst_i)
    psel_i && penable_i && !pwrite_i && !pready_o && hit_mid
      && |chan_flags_i[16*FLAGS_CH-1 -: FLAGS_CH] |=> prdata_o[7];
  endproperty
  a_sum_top: assert property (p_sum_top)
    else $error("channel 16 not summarised in bit 7");

  // ----------------------------------------------------------------
  // bus handshake checks
  // ----------------------------------------------------------------
  // an access phase that the slave has not answered yet
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  // a configuration read waiting for its answer
  sequence s_rd_cfg;
    psel_i && penable_i && !pwrite_i && !pready_o && hit_cfg;
  endsequence
  // a configuration write at the edge where it takes effect
  sequence s_wr_cfg;
    psel_i && penable_i && pwrite_i && pready_o && hit_cfg;
  endsequence
  // a summary write at the edge where a write would land
  sequence s_wr_sum;
    psel_i && penable_i && pwrite_i && pready_o && (hit_low || hit_mid);
  endsequence

  // one wait state, then the answer stands for exactly one cycle
  property p_answer;
    @(posedge sys_clk_i) disable iff (srst_i)
    s_access |=> pready_o ##1 !pready_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered after one wait state");

  // a stray address answers with an error, reads zero, writes nothing
  property p_err;
    @(posedge sys_clk_i) disable iff (srst_i)
    psel_i && penable_i && !pready_o && !(hit_cfg || hit_low || hit_mid)
      |=> pslverr_o && pready_o && prdata_o == 32'h0000_0000
      ##1 $stable(cfg_reg);
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped access not refused");

  // the error flag never stands outside an answer
  property p_err_rides;
    @(posedge sys_clk_i) disable iff (srst_i)
    pslverr_o |-> pready_o;
  endproperty
  a_err_rides: assert property (p_err_rides)
    else $error("error flag without ready");

  // a configuration write lands whole, bit 7 and above dropped
  property p_wr_cfg;
    @(posedge sys_clk_i) disable iff (srst_i)
    s_wr_cfg |=> cfg_reg == $past(pwdata_i[`RCB_ENABLE_BIT:0]);
  endproperty
  a_wr_cfg: assert property (p_wr_cfg)
    else $error("configuration write lost");

  // software reads back exactly the fields it wrote, bit 7 as zero
  property p_rd_cfg;
    @(posedge sys_clk_i) disable iff (srst_i)
    s_rd_cfg |=> pready_o && prdata_o == {25'h0, $past(cfg_reg)};
  endproperty
  a_rd_cfg: assert property (p_rd_cfg)
    else $error("configuration read wrong");

  // summaries hold no state that software could overwrite
  property p_wr_sum;
    @(posedge sys_clk_i) disable iff (srst_i)
    s_wr_sum |=> $stable(cfg_reg);
  endproperty
  a_wr_sum: assert property (p_wr_sum)
    else $error("summary write disturbed configuration");

  // every output flop goes back to its idle level in reset
  property p_rst_out;
    @(posedge sys_clk_i)
    srst_i |=> ref_out_b_oe_o && !ref_out_b_o && !ext_clk_b_rate_sel_o
      && !pready_o && !pslverr_o && prdata_o == 32'h0000_0000;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("output reset value wrong");
endmodule

// File: sim/rcb_top_tb.sv
`timescale 1ns/10ps
`include "rcb_regs.svh"
module rcb_top_tb;
  import rcb_pkg::*;
  logic         sys_clk, srst, psel, penable, pwrite, ext_clk;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         pready, pslverr, ref_out, oe, rate, err;
  logic [21:0]  rec_clk;
  logic [127:0] flags;
  int           fails, checks, cycles;
  localparam logic [11:0] CFG = `RCB_REF_B_CLOCK_SELECT_OFS;
  localparam logic [11:0] LOW = `RCB_CHAN_IRQ_SUMMARY_LOW_OFS;
  localparam logic [11:0] MID = `RCB_CHAN_IRQ_SUMMARY_MID_OFS;
  rcb_top u_rcb_top (.sys_clk_i(sys_clk), .srst_i(srst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rec_clk_i(rec_clk), .ext_clk_b_in_i(ext_clk),
    .chan_flags_i(flags), .ref_out_b_o(ref_out), .ref_out_b_oe_o(oe),
    .ext_clk_b_rate_sel_o(rate));
  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ceiling far above the under one thousand cycles the tests need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ----------------------------------------------------------------
  // apb master and expectations
  // ----------------------------------------------------------------
  // request stands until pready is seen high at a rising edge; the
  // answer is read there, before that edge's own updates land
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    logic rdy;
    rdy = 0;
    @(posedge sys_clk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1;
    while (!rdy) begin
      @(posedge sys_clk);
      rdy = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
    end
    psel    <= 0;
    penable <= 0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk("rdata", e, rd);
    chk("pslverr", 0, err);
  endtask
  function automatic logic [7:0] sum_exp(input logic [127:0] f,
                                          input int base);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = |f[(base + i) * 8 +: 8];
    return r;
  endfunction
  function automatic logic ref_exp(input logic [4:0] s);
    return (s <= `RCB_SRC_LAST_CH) ? rec_clk[s] : ext_clk;
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [4:0] s;
    logic       rt;
    srst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    rec_clk = 0;
    ext_clk = 0;
    flags = 0;
    fails = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(32'h953d7237));
    repeat (8) @(posedge sys_clk);
    srst <= 0;
    rd_chk(CFG, 32'h41);
    chk("oe", 1, oe);
    chk("rate", 0, rate);
    rd_chk(LOW, 0);
    rd_chk(MID, 0);
    $display("test reset done");
    // every selector code; bit 7 and upper bits random to prove they read 0
    for (int i = 0; i < 32; i++) begin
      s = i[4:0];
      rt = 1'($urandom);
      apb(1, CFG, ($urandom & 32'hFFFFFF80) | 32'h40 | {rt, s});
      rd_chk(CFG, {25'h0, 1'b1, rt, s});
      repeat (2) begin
        @(posedge sys_clk);
        rec_clk <= 22'($urandom);
        ext_clk <= ~ext_clk;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("ref_out", ref_exp(s), ref_out);
        chk("rate", rt, rate);
      end
    end
    $display("test source sweep done");
    // disabled: pin released even with every source high
    rec_clk <= '1;
    ext_clk <= 1;
    apb(1, CFG, 32'h15);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("oe", 0, oe);
    chk("ref_out", 0, ref_out);
    apb(1, CFG, 32'h55);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("oe", 1, oe);
    chk("ref_out", 1, ref_out);
    $display("test enable done");
    // summaries follow flags; writes there change nothing
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      if (i == 0) flags <= 128'h1 << 127;
      else if (i == 7) flags <= '0;
      else flags <= {4{$urandom & $urandom}};
      apb(1, LOW, 32'hFF);
      chk("pslverr", 0, err);
      rd_chk(LOW, {24'h0, sum_exp(flags, 0)});
      rd_chk(MID, {24'h0, sum_exp(flags, 8)});
    end
    rd_chk(LOW, 0);
    $display("test summary done");
    // unmapped places answer with an error and leave config alone
    apb(0, 12'h004, 0);
    chk("pslverr", 1, err);
    chk("rdata", 0, rd);
    apb(1, 12'h284, 32'h0);
    chk("pslverr", 1, err);
    rd_chk(CFG, 32'h55);
    $display("test unmapped done");
    // reset in mid-run brings every field back from other values
    apb(1, CFG, 32'h3E);
    rd_chk(CFG, 32'h3E);
    @(posedge sys_clk);
    srst <= 1;
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    rd_chk(CFG, 32'h41);
    chk("oe", 1, oe);
    chk("rate", 0, rate);
    chk("ref_out", 1, ref_out);
    $display("test mid reset done");
    give_verdict();
  end
endmodule
